// ==== pkg/mbx_defines.vh ====
// Functional notes
// - Goto, call, subroutine exit, exit with immediate load and interrupt exit take two cycles and touch no flags.
// - A skip instruction that skips adds one instruction cycle; one that does not keeps its base cost.
// - A memory-writing instruction aimed at the pc low byte adds one instruction cycle.
// - Increment or decrement and skip writes memory back, skips on zero and takes both penalties.
// - The working-register forms put the result in the working register only and skip on zero.
// - Bit test skips look at bit 0 to 7 and skip on clear or on set, one cycle plus skip penalty.
// - Zero test and load copies the byte to the working register and skips when it is zero.
// - With the high pointer option the page fetch addresses by both pointers, low byte to memory, high to latch.
// - Without it the page fetch reads the current page at the low pointer, same delivery, two cycles.
// - The last page fetch reads the final page at the low pointer, same delivery, two cycles.
// - Nibble exchange swaps in memory; its working-register form writes only the working register, one cycle.
// - Pre-clear instructions clear timeout and power-down flags only when the watchdog really clears.
// - Sleep entry enters power-down within one instruction cycle and updates both flags.
// - Add with carry sums working register, memory and carry into the working register and sets four flags.
`ifndef MBX_DEFINES_VH
`define MBX_DEFINES_VH
// ----------------------------------------
// Opcodes (5-bit field op_code)
// ----------------------------------------
`define MBX_OP_IDLE       5'h00
`define MBX_OP_GOTO       5'h01
`define MBX_OP_CALL       5'h02
`define MBX_OP_RET        5'h03
`define MBX_OP_RET_LOAD   5'h04
`define MBX_OP_INTERRUPT_EXIT       5'h05
`define MBX_OP_ZT_SKIP    5'h06
`define MBX_OP_ZT_LOAD    5'h07
`define MBX_OP_BIT_CLR_SK 5'h08
`define MBX_OP_BIT_SET_SK 5'h09
`define MBX_OP_INC_SK     5'h0a
`define MBX_OP_DEC_SK     5'h0b
`define MBX_OP_INC_SK_W   5'h0c
`define MBX_OP_DEC_SK_W   5'h0d
`define MBX_OP_TAB_PAGE   5'h0e
`define MBX_OP_TAB_LAST   5'h0f
`define MBX_OP_MEM_CLR    5'h10
`define MBX_OP_MEM_SET    5'h11
`define MBX_OP_WDT_CLR    5'h12
`define MBX_OP_WDT_PRE1   5'h13
`define MBX_OP_WDT_PRE2   5'h14
`define MBX_OP_SWAP       5'h15
`define MBX_OP_SWAP_W     5'h16
`define MBX_OP_SLEEP      5'h17
`define MBX_OP_ADD        5'h18
`define MBX_OP_ADD_IMM    5'h19
`define MBX_OP_ADC        5'h1a
`define MBX_OP_SUM_TO_MEM       5'h1b
`define MBX_OP_SUM_WITH_CARRY_TO_MEM       5'h1c
// ----------------------------------------
// Timing and reset values
// ----------------------------------------
`define MBX_CLKS_PER_CYC  3'h4
`define MBX_PCL_ADDR      8'h06
`define MBX_RST_BYTE      8'h00
// ----------------------------------------
// APB register map (byte addresses)
// ----------------------------------------
`define MBX_REG_CMD       12'h000
`define MBX_REG_CTRL      12'h004
`define MBX_REG_RESULT    12'h008
`define MBX_REG_STATUS    12'h00c
`define MBX_REG_TABLE     12'h010
`define MBX_CTRL_TABLE_POINTER_HIGH_BIT 0
`define MBX_CTRL_TWO_BIT  1
`endif

// ==== src/mbx_phase_div.v ====
// ----------------------------------------
// Instruction phase divider
// ----------------------------------------
module mbx_phase_div #(
    parameter WIDTH = 3
) (
    input  wire             core_clk,
    input  wire             rst_n,
    input  wire             run,
    input  wire [WIDTH-1:0] clks,
    output reg              cyc_end
);
    reg [WIDTH-1:0] cnt;

    // One pulse on the last system clock of each instruction cycle
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt     <= {WIDTH{1'b0}};
            cyc_end <= 1'b0;
        end else if (!run) begin
            cnt     <= {WIDTH{1'b0}};
            cyc_end <= 1'b0;
        end else begin
            cyc_end <= (cnt == clks - {{(WIDTH-1){1'b0}}, 1'b1} - {{(WIDTH-1){1'b0}}, 1'b1});
            cnt     <= (cnt == clks - {{(WIDTH-1){1'b0}}, 1'b1}) ? {WIDTH{1'b0}} : cnt + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
endmodule // mbx_phase_div

// ==== src/mbx_exec.v ====
// The APB register port and the placing of the registers are this design's own decisions.
`include "mbx_defines.vh"
// Executes one instruction per CMD write; software supplies operands via CMD and TABLE
// words, the block computes results, flags, cycle cost and table addresses.
module mbx_exec #(
    parameter PC_WIDTH  = 12,
    parameter CLKS_WIDTH = 3
) (
    input  wire        core_clk,
    input  wire        rst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         powerdown
);
    // ----------------------------------------
    // State machine
    // ----------------------------------------
    localparam ST_IDLE = 2'b01;
    localparam ST_RUN  = 2'b10;

    reg  [1:0]  state;
    reg  [4:0]  op_code;
    reg  [7:0]  mem_in;
    reg  [7:0]  imm;
    reg  [2:0]  bit_sel;
    reg  [7:0]  dest_addr;
    reg  [7:0]  acc;
    reg         carry;
    reg         half_carry_flag;
    reg         zero_flag;
    reg         signed_wrap_flag;
    reg         timeout_flag;
    reg         powerdown_flag;
    reg         table_pointer_high_enable;
    reg         two_step_wdt;
    reg         pre1_seen;
    reg         pre2_seen;
    reg  [7:0]  table_pointer_low;
    reg  [7:0]  table_pointer_high;
    reg  [PC_WIDTH-1:0] cur_pc;
    reg  [15:0] rom_word;
    reg  [7:0]  table_high_latch;
    reg  [7:0]  mem_out;
    reg         mem_wr;
    reg         skip;
    reg  [1:0]  cycles_left;
    reg  [2:0]  cycles_taken;
    reg         busy;
    reg  [PC_WIDTH-1:0] rom_addr;
    wire        cyc_end;

    // ----------------------------------------
    // Combinational execute
    // ----------------------------------------
    reg  [7:0]  next_acc;
    reg  [7:0]  next_mem;
    reg         next_mem_wr;
    reg         next_skip;
    reg  [2:0]  next_cost;
    reg         next_flags_arith;
    reg         next_to_mem;
    reg  [8:0]  sum;
    reg  [4:0]  lo_sum;
    reg  [7:0]  addend;
    reg         cin;
    reg  [7:0]  adj;

    always @* begin
        next_acc         = acc;
        next_mem         = mem_in;
        next_mem_wr      = 1'b0;
        next_skip        = 1'b0;
        next_cost        = 3'h1;
        next_flags_arith = 1'b0;
        next_to_mem      = 1'b0;
        addend           = (op_code == `MBX_OP_ADD_IMM) ? imm : mem_in;
        cin              = ((op_code == `MBX_OP_ADC) || (op_code == `MBX_OP_SUM_WITH_CARRY_TO_MEM)) ? carry : 1'b0;
        sum              = {1'b0, acc} + {1'b0, addend} + {8'h00, cin};
        lo_sum           = {1'b0, acc[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
        adj              = (op_code == `MBX_OP_DEC_SK || op_code == `MBX_OP_DEC_SK_W) ?
                           mem_in - 8'h01 : mem_in + 8'h01;
        case (op_code)
            `MBX_OP_GOTO, `MBX_OP_CALL, `MBX_OP_RET, `MBX_OP_INTERRUPT_EXIT: begin
                next_cost = 3'h2;
            end
            `MBX_OP_RET_LOAD: begin
                next_cost = 3'h2;
                next_acc  = imm;
            end
            `MBX_OP_ZT_SKIP: begin
                next_skip = (mem_in == 8'h00);
            end
            `MBX_OP_ZT_LOAD: begin
                next_acc  = mem_in;
                next_skip = (mem_in == 8'h00);
            end
            `MBX_OP_BIT_CLR_SK: begin
                next_skip = ~mem_in[bit_sel];
            end
            `MBX_OP_BIT_SET_SK: begin
                next_skip = mem_in[bit_sel];
            end
            `MBX_OP_INC_SK, `MBX_OP_DEC_SK: begin
                next_mem    = adj;
                next_mem_wr = 1'b1;
                next_skip   = (adj == 8'h00);
            end
            `MBX_OP_INC_SK_W, `MBX_OP_DEC_SK_W: begin
                next_acc  = adj;
                next_skip = (adj == 8'h00);
            end
            `MBX_OP_TAB_PAGE, `MBX_OP_TAB_LAST: begin
                next_cost   = 3'h2;
                next_mem    = rom_word[7:0];
                next_mem_wr = 1'b1;
            end
            `MBX_OP_MEM_CLR: begin
                next_mem    = 8'h00;
                next_mem_wr = 1'b1;
            end
            `MBX_OP_MEM_SET: begin
                next_mem    = 8'hff;
                next_mem_wr = 1'b1;
            end
            `MBX_OP_SWAP: begin
                next_mem    = {mem_in[3:0], mem_in[7:4]};
                next_mem_wr = 1'b1;
            end
            `MBX_OP_SWAP_W: begin
                next_acc = {mem_in[3:0], mem_in[7:4]};
            end
            `MBX_OP_ADD, `MBX_OP_ADD_IMM, `MBX_OP_ADC: begin
                next_acc         = sum[7:0];
                next_flags_arith = 1'b1;
            end
            `MBX_OP_SUM_TO_MEM, `MBX_OP_SUM_WITH_CARRY_TO_MEM: begin
                next_mem         = sum[7:0];
                next_mem_wr      = 1'b1;
                next_flags_arith = 1'b1;
                next_to_mem      = 1'b1;
            end
            default: begin
                next_cost = 3'h1;                                          // idle, wdt and sleep ops
            end
        endcase
        // Penalties add on top of the base cost
        if (next_mem_wr && (dest_addr == `MBX_PCL_ADDR))
            next_cost = next_cost + 3'h1;
        if (next_skip)
            next_cost = next_cost + 3'h1;
    end

    // Table address: last page has all upper bits set
    always @* begin
        if (op_code == `MBX_OP_TAB_LAST)
            rom_addr = {{(PC_WIDTH-8){1'b1}}, table_pointer_low};
        else if (table_pointer_high_enable)
            rom_addr = {table_pointer_high[PC_WIDTH-9:0], table_pointer_low};
        else
            rom_addr = {cur_pc[PC_WIDTH-1:8], table_pointer_low};
    end

    // ----------------------------------------
    // Instruction timing
    // ----------------------------------------
    mbx_phase_div #(
        .WIDTH (CLKS_WIDTH)
    ) u_div (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .run      (busy),
        .clks     (`MBX_CLKS_PER_CYC),
        .cyc_end  (cyc_end)
    );

    // Writes land at the edge that closes the access phase, where pready is sampled high
    wire wr_en = psel && penable && pwrite && pready;
    wire start = wr_en && (paddr == `MBX_REG_CMD) && !busy;

    // Execute, flags and cycle accounting
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            busy <= 1'b0;
            cycles_left <= 2'h0;
            cycles_taken <= 3'h0;
            acc <= `MBX_RST_BYTE;
            mem_out <= `MBX_RST_BYTE;
            mem_wr <= 1'b0;
            skip <= 1'b0;
            carry <= 1'b0;
            half_carry_flag <= 1'b0;
            zero_flag <= 1'b0;
            signed_wrap_flag <= 1'b0;
            timeout_flag <= 1'b0;
            powerdown_flag <= 1'b0;
            powerdown <= 1'b0;
            pre1_seen <= 1'b0;
            pre2_seen <= 1'b0;
            table_high_latch <= `MBX_RST_BYTE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        state <= ST_RUN;
                        busy <= 1'b1;
                        powerdown <= 1'b0;
                    end
                end
                ST_RUN: begin
                    if (cycles_left == 2'h0 && !cyc_end && cycles_taken == 3'h0) begin
                        // First clock: latch results, start counting cycles
                        acc <= next_acc;
                        mem_out <= next_mem;
                        mem_wr <= next_mem_wr;
                        skip <= next_skip;
                        cycles_taken <= next_cost;
                        cycles_left <= next_cost[1:0] - 2'h1;
                        if (op_code == `MBX_OP_TAB_PAGE || op_code == `MBX_OP_TAB_LAST)
                            table_high_latch <= rom_word[15:8];
                        if (next_flags_arith) begin
                            carry <= sum[8];
                            half_carry_flag <= lo_sum[4];
                            zero_flag <= (sum[7:0] == 8'h00);
                            signed_wrap_flag <= (acc[7] == addend[7]) && (sum[7] != acc[7]);
                        end
                        case (op_code)
                            `MBX_OP_WDT_CLR: begin
                                timeout_flag <= 1'b0;
                                powerdown_flag <= 1'b0;
                            end
                            `MBX_OP_WDT_PRE1, `MBX_OP_WDT_PRE2: begin
                                if (!two_step_wdt || (op_code == `MBX_OP_WDT_PRE1 ? pre2_seen : pre1_seen)) begin
                                    timeout_flag <= 1'b0;
                                    powerdown_flag <= 1'b0;
                                    pre1_seen <= 1'b0;
                                    pre2_seen <= 1'b0;
                                end else if (op_code == `MBX_OP_WDT_PRE1) begin
                                    pre1_seen <= 1'b1;
                                end else begin
                                    pre2_seen <= 1'b1;
                                end
                            end
                            `MBX_OP_SLEEP: begin
                                timeout_flag <= 1'b0;
                                powerdown_flag <= 1'b1;
                                powerdown <= 1'b1;
                            end
                            default: begin
                                mem_wr <= next_mem_wr;
                            end
                        endcase
                    end else if (cyc_end) begin
                        if (cycles_left == 2'h0) begin
                            state <= ST_IDLE;
                            busy <= 1'b0;
                        end else begin
                            cycles_left <= cycles_left - 2'h1;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    busy <= 1'b0;
                end
            endcase
            if (start)
                cycles_taken <= 3'h0;
        end
    end

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    // Command word: [4:0] op, [7:5] bit, [15:8] memory byte, [23:16] immediate, [31:24] destination
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            op_code <= `MBX_OP_IDLE;
            bit_sel <= 3'h0;
            mem_in <= `MBX_RST_BYTE;
            imm <= `MBX_RST_BYTE;
            dest_addr <= `MBX_RST_BYTE;
            table_pointer_high_enable <= 1'b0;
            two_step_wdt <= 1'b0;
            table_pointer_low <= `MBX_RST_BYTE;
            table_pointer_high <= `MBX_RST_BYTE;
            cur_pc <= {PC_WIDTH{1'b0}};
            rom_word <= 16'h0000;
        end else if (wr_en) begin
            case (paddr)
                `MBX_REG_CMD: begin
                    if (!busy) begin
                        op_code <= pwdata[4:0];
                        bit_sel <= pwdata[7:5];
                        mem_in <= pwdata[15:8];
                        imm <= pwdata[23:16];
                        dest_addr <= pwdata[31:24];
                    end
                end
                `MBX_REG_CTRL: begin
                    table_pointer_high_enable <= pwdata[`MBX_CTRL_TABLE_POINTER_HIGH_BIT];
                    two_step_wdt <= pwdata[`MBX_CTRL_TWO_BIT];
                    cur_pc <= pwdata[16+PC_WIDTH-1:16];
                end
                `MBX_REG_TABLE: begin
                    table_pointer_low <= pwdata[7:0];
                    table_pointer_high <= pwdata[15:8];
                    rom_word <= pwdata[31:16];
                end
                default: begin
                    rom_word <= rom_word;
                end
            endcase
        end
    end

    // Single-wait-state answer; unmapped addresses raise pslverr
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= (paddr != `MBX_REG_CMD) && (paddr != `MBX_REG_CTRL) && (paddr != `MBX_REG_RESULT) &&
                       (paddr != `MBX_REG_STATUS) && (paddr != `MBX_REG_TABLE);
            case (paddr)
                `MBX_REG_CMD:    prdata <= {dest_addr, imm, mem_in, bit_sel, op_code};
                `MBX_REG_CTRL:   prdata <= {{(16-PC_WIDTH){1'b0}}, cur_pc, 14'h0000, two_step_wdt, table_pointer_high_enable};
                `MBX_REG_RESULT: prdata <= {table_high_latch, mem_out, acc, rom_addr[PC_WIDTH-1:PC_WIDTH-4], 4'h0};
                `MBX_REG_STATUS: prdata <= {17'h00000, cycles_taken, busy, skip, mem_wr, powerdown,
                                            timeout_flag, powerdown_flag, signed_wrap_flag, zero_flag,
                                            half_carry_flag, carry, 2'h0};
                `MBX_REG_TABLE:  prdata <= {rom_word, table_pointer_high, table_pointer_low};
                default:         prdata <= 32'h0000_0000;
            endcase
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end
endmodule // mbx_exec

// ==== sim/mbx_exec_asserts.sv ====
`include "mbx_defines.vh"
module mbx_exec_asserts (
    input logic        core_clk,
    input logic        rst_n,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic        powerdown
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // --------------------------------
    // Bus answer and command capture
    // --------------------------------
    // A command lands only at the edge that closes its access phase
    logic cmd_wr;
    assign cmd_wr = psel && penable && pready && pwrite && paddr == `MBX_REG_CMD;
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready held two cycles");
    ready_bound_a: assert property (psel && penable && !pready |-> ##[0:1] pready) else $error("answer late");
    ready_owner_a: assert property (pready |-> psel && penable) else $error("answer without request");
    err_decode_a: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > `MBX_REG_TABLE))
        else $error("error flag wrong for address");
    err_paired_a: assert property (pslverr |-> pready) else $error("error flag without answer");
    err_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read not zero");
    sleep_enter_a: assert property (cmd_wr && pwdata[4:0] == `MBX_OP_SLEEP |-> ##[1:5] powerdown)
        else $error("power down late");
    sleep_leave_a: assert property (powerdown && cmd_wr && pwdata[4:0] != `MBX_OP_SLEEP |-> ##[1:5] !powerdown)
        else $error("power down kept after command");
endmodule // mbx_exec_asserts
bind mbx_exec mbx_exec_asserts i_chk (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .powerdown(powerdown));

// ==== sim/mbx_exec_tb_top.sv ====
`include "mbx_defines.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module mbx_exec_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        powerdown;
    int          err_count = 0;
    int          comparisons = 0;
    logic [31:0] seed = 32'hb92c1b49;
    logic [66:0] notes[$];
    logic [66:0] note;
    logic [4:0]  adds[5] = '{`MBX_OP_ADD_IMM, `MBX_OP_ADD, `MBX_OP_ADC, `MBX_OP_SUM_TO_MEM, `MBX_OP_SUM_WITH_CARRY_TO_MEM};
    logic [4:0]  brs[5] = '{`MBX_OP_RET_LOAD, `MBX_OP_GOTO, `MBX_OP_CALL, `MBX_OP_RET, `MBX_OP_INTERRUPT_EXIT};
    // ------------------------------
    // Clock, design and monitor
    // ------------------------------
    always #12.5 core_clk = ~core_clk;
    mbx_exec i_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .powerdown(powerdown));
    // Read answers pair with the oldest note; polls carry a note that is not checked
    always @(posedge core_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && notes.size() != 0) begin
            note = notes.pop_front();
            if (note[66]) `CHK({pslverr, prdata} & note[65:33], note[32:0])
        end
    end
    // ------------------------------
    // Stimulus helpers
    // ------------------------------
    function automatic logic [7:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    // Returns {wrap, zero, half, carry, sum}, the order of the status flag field
    function automatic logic [11:0] addf(input logic [7:0] x, input logic [7:0] y, input logic ci);
        logic [8:0] s;
        s = x + y + ci;
        return {(x[7] == y[7]) && (s[7] != x[7]), s[7:0] == 8'h00, (x[3:0] + y[3:0] + ci) > 5'h0f, s[8], s[7:0]};
    endfunction
    // Request held until pready is seen high at a rising edge; wait bounded
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) err_count++;
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] m, input logic [32:0] e);
        logic [31:0] q;
        notes.push_back({1'b1, m, e & m});
        apb(1'b0, a, 32'h0, q);
    endtask
    // Issue one command, then poll until busy drops
    task automatic op_chk(input logic [4:0] op, input logic [2:0] b, input logic [7:0] m, input logic [7:0] imm,
                          input logic [7:0] dst, input logic [2:0] cyc, input logic sk, input logic mw,
                          input logic [31:0] rm, input logic [31:0] re);
        logic [31:0] q;
        int n;
        n = 0;
        apb(1'b1, `MBX_REG_CMD, {dst, imm, m, b, op}, q);
        do begin
            notes.push_back(67'h0);
            apb(1'b0, `MBX_REG_STATUS, 32'h0, q);
            n++;
        end while (q[11] !== 1'b0 && n < 40);
        if (n >= 40) err_count++;
        rd(`MBX_REG_STATUS, 33'h100007e00, {1'b0, 17'h0, cyc, 1'b0, sk, mw, 9'h0});
        if (rm != 32'h0) rd(`MBX_REG_RESULT, {1'b1, rm}, {1'b0, re});
    endtask
    task automatic conclude();
        $display("comparisons=%0d err_count=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ------------------------------
    // Scenarios
    // ------------------------------
    initial begin
        logic [31:0] q;
        logic [15:0] w;
        logic [11:0] r;
        logic [7:0]  m;
        logic [7:0]  acc;
        logic        cy;
        logic        mw;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        `CHK({pready, pslverr, powerdown}, 3'b000)
        rd(12'h020, 33'h1ffffffff, 33'h100000000);
        // Only the first branch may load the immediate into acc
        foreach (brs[i]) op_chk(brs[i], 3'h0, 8'h00, i == 0 ? 8'h5a : 8'ha5, 8'h10, 3'h2, 1'b0, 1'b0, 32'hff00, 32'h5a00);
        op_chk(`MBX_OP_ZT_SKIP, 3'h0, 8'h00, 8'h00, 8'h10, 3'h2, 1'b1, 1'b0, 32'h0, 32'h0);
        op_chk(`MBX_OP_ZT_SKIP, 3'h0, 8'h05, 8'h00, 8'h10, 3'h1, 1'b0, 1'b0, 32'h0, 32'h0);
        op_chk(`MBX_OP_ZT_LOAD, 3'h0, 8'h00, 8'h00, 8'h10, 3'h2, 1'b1, 1'b0, 32'hff00, 32'h0000);
        op_chk(`MBX_OP_ZT_LOAD, 3'h0, 8'h81, 8'h00, 8'h10, 3'h1, 1'b0, 1'b0, 32'hff00, 32'h8100);
        for (int i = 0; i < 8; i++) begin
            m = xs() | (8'h01 << i);
            op_chk(`MBX_OP_BIT_SET_SK, i[2:0], m, 8'h00, 8'h10, 3'h2, 1'b1, 1'b0, 32'h0, 32'h0);
            op_chk(`MBX_OP_BIT_CLR_SK, i[2:0], m, 8'h00, 8'h10, 3'h1, 1'b0, 1'b0, 32'h0, 32'h0);
            op_chk(`MBX_OP_BIT_CLR_SK, i[2:0], m & ~(8'h01 << i), 8'h00, 8'h10, 3'h2, 1'b1, 1'b0, 32'h0, 32'h0);
        end
        op_chk(`MBX_OP_INC_SK, 3'h0, 8'hff, 8'h00, 8'h06, 3'h3, 1'b1, 1'b1, 32'hff0000, 32'h000000);
        op_chk(`MBX_OP_DEC_SK, 3'h0, 8'h05, 8'h00, 8'h06, 3'h2, 1'b0, 1'b1, 32'hff0000, 32'h040000);
        op_chk(`MBX_OP_INC_SK_W, 3'h0, 8'hff, 8'h00, 8'h06, 3'h2, 1'b1, 1'b0, 32'hff00, 32'h0000);
        op_chk(`MBX_OP_DEC_SK_W, 3'h0, 8'h10, 8'h00, 8'h06, 3'h1, 1'b0, 1'b0, 32'hff00, 32'h0f00);
        // Table fetches with and without the high pointer option
        w = {xs(), xs()};
        apb(1'b1, `MBX_REG_TABLE, {w, 16'h0312}, q);
        apb(1'b1, `MBX_REG_CTRL, 32'h0a50_0001, q);
        op_chk(`MBX_OP_TAB_PAGE, 3'h0, 8'h00, 8'h00, 8'h10, 3'h2, 1'b0, 1'b1, 32'hffff00f0, {w, 16'h30});
        apb(1'b1, `MBX_REG_CTRL, 32'h0a50_0000, q);
        op_chk(`MBX_OP_TAB_PAGE, 3'h0, 8'h00, 8'h00, 8'h10, 3'h2, 1'b0, 1'b1, 32'hffff00f0, {w, 16'ha0});
        op_chk(`MBX_OP_TAB_LAST, 3'h0, 8'h00, 8'h00, 8'h06, 3'h3, 1'b0, 1'b1, 32'hffff00f0, {w, 16'hf0});
        op_chk(`MBX_OP_IDLE, 3'h0, 8'h00, 8'h00, 8'h06, 3'h1, 1'b0, 1'b0, 32'h0, 32'h0);
        op_chk(`MBX_OP_MEM_CLR, 3'h0, 8'h77, 8'h00, 8'h06, 3'h2, 1'b0, 1'b1, 32'hff0000, 32'h000000);
        op_chk(`MBX_OP_MEM_SET, 3'h0, 8'h00, 8'h00, 8'h10, 3'h1, 1'b0, 1'b1, 32'hff0000, 32'hff0000);
        op_chk(`MBX_OP_SWAP, 3'h0, 8'h3c, 8'h00, 8'h06, 3'h2, 1'b0, 1'b1, 32'hff0000, 32'hc30000);
        op_chk(`MBX_OP_SWAP_W, 3'h0, 8'h5e, 8'h00, 8'h06, 3'h1, 1'b0, 1'b0, 32'hff00, 32'he500);
        // Sleep, then one-step and two-step watchdog clears
        op_chk(`MBX_OP_SLEEP, 3'h0, 8'h00, 8'h00, 8'h10, 3'h1, 1'b0, 1'b0, 32'h0, 32'h0);
        `CHK(powerdown, 1'b1)
        rd(`MBX_REG_STATUS, 33'h1c0, 33'h140);
        op_chk(`MBX_OP_WDT_CLR, 3'h0, 8'h00, 8'h00, 8'h10, 3'h1, 1'b0, 1'b0, 32'h0, 32'h0);
        `CHK(powerdown, 1'b0)
        rd(`MBX_REG_STATUS, 33'h1c0, 33'h000);
        apb(1'b1, `MBX_REG_CTRL, 32'h2, q);
        op_chk(`MBX_OP_SLEEP, 3'h0, 8'h00, 8'h00, 8'h10, 3'h1, 1'b0, 1'b0, 32'h0, 32'h0);
        op_chk(`MBX_OP_WDT_PRE1, 3'h0, 8'h00, 8'h00, 8'h10, 3'h1, 1'b0, 1'b0, 32'h0, 32'h0);
        rd(`MBX_REG_STATUS, 33'hc0, 33'h40);
        op_chk(`MBX_OP_WDT_PRE2, 3'h0, 8'h00, 8'h00, 8'h10, 3'h1, 1'b0, 1'b0, 32'h0, 32'h0);
        rd(`MBX_REG_STATUS, 33'hc0, 33'h00);
        // Random add chains; carry flows from one add into the next
        for (int k = 0; k < 4; k++) begin
            acc = xs();
            cy = 1'b0;
            op_chk(`MBX_OP_RET_LOAD, 3'h0, 8'h00, acc, 8'h10, 3'h2, 1'b0, 1'b0, 32'hff00, {16'h0, acc, 8'h0});
            foreach (adds[j]) begin
                m = xs();
                r = addf(acc, m, (adds[j] == `MBX_OP_ADC || adds[j] == `MBX_OP_SUM_WITH_CARRY_TO_MEM) ? cy : 1'b0);
                mw = adds[j] >= `MBX_OP_SUM_TO_MEM;
                op_chk(adds[j], 3'h0, m, m, mw ? 8'h06 : 8'h10, mw ? 3'h2 : 3'h1, 1'b0, mw, mw ? 32'hff0000 : 32'hff00,
                       mw ? {8'h0, r[7:0], 16'h0} : {16'h0, r[7:0], 8'h0});
                rd(`MBX_REG_STATUS, 33'h3c, {27'h0, r[11:8], 2'h0});
                cy = r[8];
                if (!mw) acc = r[7:0];
            end
        end
        conclude();
    end
    // Cuts a hang short well past the expected run length
    initial begin
        #500000;
        err_count++;
        conclude();
    end
endmodule // mbx_exec_tb_top
